/* logic/scc_pkg.sv */
// Constants, register map and field layout of the sense channel register bank
// Summary of operation
// - Channel counts readable as 16-bit low/high bytes
// - Long-term averages readable, read-only, 16-bit
// - Mode bits 7-4: 0000 self-cap, 1001 inductive
// - Transmit select 00 disables both transmit electrodes
// - Receive select: none, rx0, rx1, both
// - Shared bit 6 picks small/large sense capacitor
// - Shared bits 5-4 set charge divider 2-16
// - Shared bits 3-2 pick bias, ascending current
// - Shared bits 1-0 pick auto-tuning mode
// - Tuning base 75/100/150/200 from bits 7-6
// - Tuning target is six-bit field times 32
// - Filter bit 6 enables sampling capacitor divider
// - Filter bit 5 enables two-sided detection
// - Filter bit 4 bypasses alternating filter
// - Ten-bit offset: low register plus bits 7-6
// - Gain register: coarse bits 5-4, fine 3-0
// - Channel 0 gain at 0x48, channel 1 next
// - Flag event when average minus count exceeds threshold
package scc_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_COUNT = 6;
  localparam int unsigned NUM_FUSED = 2;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned RES_W     = 16;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_COUNT_BASE = 8'h20;
  localparam logic [7:0] ADDR_COUNT_LAST = 8'h2b;
  localparam logic [7:0] ADDR_LTA_BASE   = 8'h30;
  localparam logic [7:0] ADDR_LTA_LAST   = 8'h33;
  localparam logic [7:0] ADDR_CH0_METHOD = 8'h40;
  localparam logic [7:0] ADDR_CH1_METHOD = 8'h41;
  localparam logic [7:0] ADDR_FRONTEND   = 8'h42;
  localparam logic [7:0] ADDR_CH0_TUNING = 8'h43;
  localparam logic [7:0] ADDR_CH1_TUNING = 8'h44;
  localparam logic [7:0] ADDR_FILTER     = 8'h45;
  localparam logic [7:0] ADDR_CH0_OFFSET = 8'h46;
  localparam logic [7:0] ADDR_CH1_OFFSET = 8'h47;
  localparam logic [7:0] ADDR_CH0_GAIN   = 8'h48;
  localparam logic [7:0] ADDR_CH1_GAIN   = 8'h49;
  localparam logic [7:0] ADDR_THR_BASE   = 8'h50;
  localparam logic [7:0] ADDR_THR_LAST   = 8'h53;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_METHOD   = 8'h00;
  localparam logic [7:0] RST_FRONTEND = 8'h5b;
  localparam logic [7:0] RST_TUNING   = 8'h50;
  localparam logic [7:0] RST_FILTER   = 8'h00;
  localparam logic [7:0] RST_OFFSET   = 8'h00;
  localparam logic [7:0] RST_GAIN     = 8'h00;
  localparam logic [7:0] RST_THRESH   = 8'h00;
  localparam logic [7:0] READ_ZERO    = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int unsigned MODE_MSB   = 7;
  localparam int unsigned MODE_LSB   = 4;
  localparam int unsigned TX_MSB     = 3;
  localparam int unsigned TX_LSB     = 2;
  localparam int unsigned RX_MSB     = 1;
  localparam int unsigned RX_LSB     = 0;
  localparam int unsigned CAP_BIT    = 6;
  localparam int unsigned FREQ_MSB   = 5;
  localparam int unsigned FREQ_LSB   = 4;
  localparam int unsigned BIAS_MSB   = 3;
  localparam int unsigned BIAS_LSB   = 2;
  localparam int unsigned TUNE_MSB   = 1;
  localparam int unsigned TUNE_LSB   = 0;
  localparam int unsigned BASE_MSB   = 7;
  localparam int unsigned BASE_LSB   = 6;
  localparam int unsigned TGT_MSB    = 5;
  localparam int unsigned TGT_LSB    = 0;
  localparam int unsigned TGT_SHIFT  = 5;
  localparam int unsigned DIV_BIT    = 6;
  localparam int unsigned TWO_BIT    = 5;
  localparam int unsigned BYP_BIT    = 4;
  localparam int unsigned LBETA_MSB  = 3;
  localparam int unsigned LBETA_LSB  = 2;
  localparam int unsigned ABETA_MSB  = 1;
  localparam int unsigned ABETA_LSB  = 0;
  localparam int unsigned OFSH_MSB   = 7;
  localparam int unsigned OFSH_LSB   = 6;
  localparam int unsigned COARSE_MSB = 5;
  localparam int unsigned COARSE_LSB = 4;
  localparam int unsigned FINE_MSB   = 3;
  localparam int unsigned FINE_LSB   = 0;

  // ==========================================================================
  // Encodings and decoded values
  localparam logic [3:0] MODE_SELF_CAP = 4'h0;
  localparam logic [3:0] MODE_MUT_IND  = 4'h9;
  localparam logic [7:0] BASE_V0       = 8'h4b;
  localparam logic [7:0] BASE_V1       = 8'h64;
  localparam logic [7:0] BASE_V2       = 8'h96;
  localparam logic [7:0] BASE_V3       = 8'hc8;
  localparam logic [3:0] LBETA_OFS     = 4'h7;
  localparam logic [2:0] ABETA_OFS     = 3'h1;
  localparam logic [4:0] DIV_ONE       = 5'h01;

  typedef enum logic [1:0] {
    SCC_TUNE_OFF     = 2'h0,
    SCC_TUNE_PARTIAL = 2'h1,
    SCC_TUNE_SEMI    = 2'h2,
    SCC_TUNE_FULL    = 2'h3
  } scc_tune_e;

endpackage

/* logic/scc_chan_cfg.sv */
// Per-channel decode of method, tuning and offset/gain settings
`timescale 1ns/1ps
module scc_chan_cfg (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  method_in,
  input  wire logic [7:0]  tuning_in,
  input  wire logic [7:0]  offset_in,
  input  wire logic [7:0]  gain_in,
  output logic             self_cap_out,
  output logic             mutual_ind_out,
  output logic [1:0]       tx_en_out,
  output logic [1:0]       rx_en_out,
  output logic [7:0]       tune_base_out,
  output logic [10:0]      tune_target_out,
  output logic [9:0]       offset_out,
  output logic [1:0]       coarse_out,
  output logic [3:0]       fine_out
);

  logic [3:0] mode;
  logic [1:0] base_code;
  logic [7:0] next_base;

  assign mode      = method_in[scc_pkg::MODE_MSB:scc_pkg::MODE_LSB];
  assign base_code = tuning_in[scc_pkg::BASE_MSB:scc_pkg::BASE_LSB];

  always_comb begin
    unique case (base_code)
      2'h0: next_base = scc_pkg::BASE_V0;
      2'h1: next_base = scc_pkg::BASE_V1;
      2'h2: next_base = scc_pkg::BASE_V2;
      2'h3: next_base = scc_pkg::BASE_V3;
    endcase
  end

  // ==========================================================================
  // Registered decode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      self_cap_out    <= 1'b0;
      mutual_ind_out  <= 1'b0;
      tx_en_out       <= 2'h0;
      rx_en_out       <= 2'h0;
      tune_base_out   <= 8'h00;
      tune_target_out <= 11'h000;
      offset_out      <= 10'h000;
      coarse_out      <= 2'h0;
      fine_out        <= 4'h0;
    end else begin
      self_cap_out    <= (mode == scc_pkg::MODE_SELF_CAP);
      mutual_ind_out  <= (mode == scc_pkg::MODE_MUT_IND);
      tx_en_out       <= method_in[scc_pkg::TX_MSB:scc_pkg::TX_LSB];
      rx_en_out       <= method_in[scc_pkg::RX_MSB:scc_pkg::RX_LSB];
      tune_base_out   <= next_base;
      tune_target_out <= {tuning_in[scc_pkg::TGT_MSB:scc_pkg::TGT_LSB],
                          5'h00};
      offset_out      <= {gain_in[scc_pkg::OFSH_MSB:scc_pkg::OFSH_LSB], offset_in};
      coarse_out      <= gain_in[scc_pkg::COARSE_MSB:scc_pkg::COARSE_LSB];
      fine_out        <= gain_in[scc_pkg::FINE_MSB:scc_pkg::FINE_LSB];
    end
  end

endmodule

/* logic/scc_regs.sv */
// Sense channel register bank: results, front-end settings and event flags
`timescale 1ns/1ps
module scc_regs (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // Byte register port from the serial slave engine
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic                    reg_wr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_rd_in,
  output logic [7:0]                   reg_rdata_out,
  output logic                         reg_rvalid_out,
  // Measurement results
  input  wire logic                    result_load_in,
  input  wire logic [5:0][15:0]        raw_count_in,
  input  wire logic [1:0][15:0]        filt_count_in,
  input  wire logic [1:0][15:0]        lta_in,
  // Per-channel front-end controls
  output logic [1:0]                   self_cap_out,
  output logic [1:0]                   mutual_ind_out,
  output logic [1:0][1:0]              tx_en_out,
  output logic [1:0][1:0]              rx_en_out,
  output logic [1:0][7:0]              tune_base_out,
  output logic [1:0][10:0]             tune_target_out,
  output logic [1:0][9:0]              offset_out,
  output logic [1:0][1:0]              coarse_out,
  output logic [1:0][3:0]              fine_out,
  // Shared front-end controls
  output logic                         cap_large_out,
  output logic [4:0]                   charge_div_out,
  output logic [1:0]                   bias_sel_out,
  output scc_pkg::scc_tune_e           tune_mode_out,
  output logic                         cs_div_en_out,
  output logic                         two_sided_out,
  output logic                         filter_bypass_out,
  output logic [3:0]                   lta_beta_out,
  output logic [2:0]                   acf_beta_out,
  // Events
  output logic [1:0]                   prox_out,
  output logic [1:0]                   touch_out
);

  // ==========================================================================
  // Storage
  logic [7:0]             method_reg [2];
  logic [7:0]             tuning_reg [2];
  logic [7:0]             offset_reg [2];
  logic [7:0]             gain_reg   [2];
  logic [7:0]             frontend_reg;
  logic [7:0]             filter_reg;
  logic [7:0]             thresh_reg [4];
  logic [15:0]            count_res  [scc_pkg::NUM_COUNT];
  logic [15:0]            lta_res    [scc_pkg::NUM_FUSED];
  logic [7:0]             high_shadow;

  // ==========================================================================
  // Address decode
  logic                   hit_count;
  logic                   hit_lta;
  logic                   hit_thr;
  logic [7:0]             count_ofs;
  logic [7:0]             lta_ofs;
  logic [7:0]             thr_ofs;
  logic [2:0]             count_idx;
  logic                   lta_idx;
  logic [1:0]             thr_idx;
  logic                   high_sel;

  assign hit_count = (reg_addr_in >= scc_pkg::ADDR_COUNT_BASE) &&
                     (reg_addr_in <= scc_pkg::ADDR_COUNT_LAST);
  assign hit_lta   = (reg_addr_in >= scc_pkg::ADDR_LTA_BASE) &&
                     (reg_addr_in <= scc_pkg::ADDR_LTA_LAST);
  assign hit_thr   = (reg_addr_in >= scc_pkg::ADDR_THR_BASE) &&
                     (reg_addr_in <= scc_pkg::ADDR_THR_LAST);
  assign count_ofs = reg_addr_in - scc_pkg::ADDR_COUNT_BASE;
  assign lta_ofs   = reg_addr_in - scc_pkg::ADDR_LTA_BASE;
  assign thr_ofs   = reg_addr_in - scc_pkg::ADDR_THR_BASE;
  assign count_idx = count_ofs[3:1];
  assign lta_idx   = lta_ofs[1];
  assign thr_idx   = thr_ofs[1:0];
  // Low byte at even address, high byte at odd
  assign high_sel  = reg_addr_in[0];

  // ==========================================================================
  // Result capture
  logic [15:0]            next_count [scc_pkg::NUM_COUNT];

  always_comb begin
    for (int i = 0; i < scc_pkg::NUM_COUNT; i++) begin
      next_count[i] = raw_count_in[i];
    end
    for (int i = 0; i < scc_pkg::NUM_FUSED; i++) begin
      next_count[i] = filter_reg[scc_pkg::BYP_BIT] ? raw_count_in[i]
                                                  : filt_count_in[i];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < scc_pkg::NUM_COUNT; i++) begin
        count_res[i] <= 16'h0000;
      end
      for (int i = 0; i < scc_pkg::NUM_FUSED; i++) begin
        lta_res[i] <= 16'h0000;
      end
    end else if (result_load_in) begin
      for (int i = 0; i < scc_pkg::NUM_COUNT; i++) begin
        count_res[i] <= next_count[i];
      end
      for (int i = 0; i < scc_pkg::NUM_FUSED; i++) begin
        lta_res[i] <= lta_in[i];
      end
    end
  end

  // ==========================================================================
  // Settings writes; result registers ignore writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      method_reg[0] <= scc_pkg::RST_METHOD;
      method_reg[1] <= scc_pkg::RST_METHOD;
      tuning_reg[0] <= scc_pkg::RST_TUNING;
      tuning_reg[1] <= scc_pkg::RST_TUNING;
      offset_reg[0] <= scc_pkg::RST_OFFSET;
      offset_reg[1] <= scc_pkg::RST_OFFSET;
      gain_reg[0]   <= scc_pkg::RST_GAIN;
      gain_reg[1]   <= scc_pkg::RST_GAIN;
      frontend_reg  <= scc_pkg::RST_FRONTEND;
      filter_reg    <= scc_pkg::RST_FILTER;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        scc_pkg::ADDR_CH0_METHOD: method_reg[0] <= reg_wdata_in;
        scc_pkg::ADDR_CH1_METHOD: method_reg[1] <= reg_wdata_in;
        scc_pkg::ADDR_FRONTEND:   frontend_reg  <= reg_wdata_in;
        scc_pkg::ADDR_CH0_TUNING: tuning_reg[0] <= reg_wdata_in;
        scc_pkg::ADDR_CH1_TUNING: tuning_reg[1] <= reg_wdata_in;
        scc_pkg::ADDR_FILTER:     filter_reg    <= reg_wdata_in;
        scc_pkg::ADDR_CH0_OFFSET: offset_reg[0] <= reg_wdata_in;
        scc_pkg::ADDR_CH1_OFFSET: offset_reg[1] <= reg_wdata_in;
        scc_pkg::ADDR_CH0_GAIN:   gain_reg[0]   <= reg_wdata_in;
        scc_pkg::ADDR_CH1_GAIN:   gain_reg[1]   <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        thresh_reg[i] <= scc_pkg::RST_THRESH;
      end
    end else if (reg_wr_in && hit_thr) begin
      thresh_reg[thr_idx] <= reg_wdata_in;
    end
  end

  // ==========================================================================
  // Read path
  logic [7:0]             next_rdata;

  always_comb begin
    next_rdata = scc_pkg::READ_ZERO;
    if (hit_count) begin
      next_rdata = high_sel ? high_shadow : count_res[count_idx][7:0];
    end else if (hit_lta) begin
      next_rdata = high_sel ? high_shadow : lta_res[lta_idx][7:0];
    end else if (hit_thr) begin
      next_rdata = thresh_reg[thr_idx];
    end else begin
      unique case (reg_addr_in)
        scc_pkg::ADDR_CH0_METHOD: next_rdata = method_reg[0];
        scc_pkg::ADDR_CH1_METHOD: next_rdata = method_reg[1];
        scc_pkg::ADDR_FRONTEND:   next_rdata = frontend_reg;
        scc_pkg::ADDR_CH0_TUNING: next_rdata = tuning_reg[0];
        scc_pkg::ADDR_CH1_TUNING: next_rdata = tuning_reg[1];
        scc_pkg::ADDR_FILTER:     next_rdata = filter_reg;
        scc_pkg::ADDR_CH0_OFFSET: next_rdata = offset_reg[0];
        scc_pkg::ADDR_CH1_OFFSET: next_rdata = offset_reg[1];
        scc_pkg::ADDR_CH0_GAIN:   next_rdata = gain_reg[0];
        scc_pkg::ADDR_CH1_GAIN:   next_rdata = gain_reg[1];
        default:                  next_rdata = scc_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out  <= scc_pkg::READ_ZERO;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  // Low byte read freezes its high byte for the following read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_shadow <= scc_pkg::READ_ZERO;
    end else if (reg_rd_in && !high_sel) begin
      if (hit_count) begin
        high_shadow <= count_res[count_idx][15:8];
      end else if (hit_lta) begin
        high_shadow <= lta_res[lta_idx][15:8];
      end
    end
  end

  // ==========================================================================
  // Shared front-end decode
  logic [1:0]             freq_code;

  assign freq_code = frontend_reg[scc_pkg::FREQ_MSB:scc_pkg::FREQ_LSB];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_large_out     <= 1'b0;
      charge_div_out    <= scc_pkg::DIV_ONE;
      bias_sel_out      <= 2'h0;
      tune_mode_out     <= scc_pkg::SCC_TUNE_OFF;
      cs_div_en_out     <= 1'b0;
      two_sided_out     <= 1'b0;
      filter_bypass_out <= 1'b0;
      lta_beta_out      <= scc_pkg::LBETA_OFS;
      acf_beta_out      <= scc_pkg::ABETA_OFS;
    end else begin
      cap_large_out     <= frontend_reg[scc_pkg::CAP_BIT];
      charge_div_out    <= scc_pkg::DIV_ONE << ({1'b0, freq_code} + 3'h1);
      bias_sel_out      <= frontend_reg[scc_pkg::BIAS_MSB:scc_pkg::BIAS_LSB];
      tune_mode_out     <= scc_pkg::scc_tune_e'(
                             frontend_reg[scc_pkg::TUNE_MSB:scc_pkg::TUNE_LSB]);
      cs_div_en_out     <= filter_reg[scc_pkg::DIV_BIT];
      two_sided_out     <= filter_reg[scc_pkg::TWO_BIT];
      filter_bypass_out <= filter_reg[scc_pkg::BYP_BIT];
      lta_beta_out      <= scc_pkg::LBETA_OFS +
                           {2'h0, filter_reg[scc_pkg::LBETA_MSB:scc_pkg::LBETA_LSB]};
      acf_beta_out      <= scc_pkg::ABETA_OFS +
                           {1'b0, filter_reg[scc_pkg::ABETA_MSB:scc_pkg::ABETA_LSB]};
    end
  end

  // ==========================================================================
  // Per-channel decode
  for (genvar c = 0; c < scc_pkg::NUM_FUSED; c++) begin : g_chan
    scc_chan_cfg u_cfg (
      .clk_in          (clk_in),
      .rst_n_in        (rst_n_in),
      .method_in       (method_reg[c]),
      .tuning_in       (tuning_reg[c]),
      .offset_in       (offset_reg[c]),
      .gain_in         (gain_reg[c]),
      .self_cap_out    (self_cap_out[c]),
      .mutual_ind_out  (mutual_ind_out[c]),
      .tx_en_out       (tx_en_out[c]),
      .rx_en_out       (rx_en_out[c]),
      .tune_base_out   (tune_base_out[c]),
      .tune_target_out (tune_target_out[c]),
      .offset_out      (offset_out[c]),
      .coarse_out      (coarse_out[c]),
      .fine_out        (fine_out[c])
    );
  end

  // ==========================================================================
  // Proximity and touch events
  logic [15:0]            delta [scc_pkg::NUM_FUSED];

  always_comb begin
    for (int i = 0; i < scc_pkg::NUM_FUSED; i++) begin
      if (lta_res[i] >= count_res[i]) begin
        delta[i] = lta_res[i] - count_res[i];
      end else if (filter_reg[scc_pkg::TWO_BIT]) begin
        delta[i] = count_res[i] - lta_res[i];
      end else begin
        delta[i] = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prox_out  <= 2'h0;
      touch_out <= 2'h0;
    end else begin
      for (int i = 0; i < scc_pkg::NUM_FUSED; i++) begin
        prox_out[i]  <= delta[i] > {8'h00, thresh_reg[2 * i]};
        touch_out[i] <= delta[i] > {8'h00, thresh_reg[2 * i + 1]};
      end
    end
  end

endmodule

/* test/scc_host.sv */
// Host model issuing byte register accesses to the bank
`timescale 1ns/1ps
module scc_host (
  input  wire logic       clk_in,
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in
);
  initial begin
    addr_out  = 8'hff;
    wr_out    = 1'b0;
    wdata_out = 8'h00;
    rd_out    = 1'b0;
  end
  // Released lines show the inverse of the last value
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
    @(negedge clk_in);
  endtask
  // Callers read the low byte before its high byte
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    rd_out   = 1'b0;
    addr_out = ~a;
    n        = 0;
    while (rvalid_in !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
  endtask
endmodule

/* test/scc_regs_chk.sv */
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
module scc_regs_chk (
  input wire logic            clk_in,
  input wire logic            rst_n_in,
  input wire logic [7:0]      reg_addr_in,
  input wire logic            reg_wr_in,
  input wire logic [7:0]      reg_wdata_in,
  input wire logic            reg_rd_in,
  input wire logic            reg_rvalid_out,
  input wire logic [1:0]      self_cap_out,
  input wire logic [1:0]      mutual_ind_out,
  input wire logic [1:0][10:0] tune_target_out,
  input wire logic [1:0][9:0] offset_out,
  input wire logic            cap_large_out,
  input wire logic [4:0]      charge_div_out,
  input wire logic [1:0]      bias_sel_out,
  input wire logic            filter_bypass_out,
  input wire logic [3:0]      lta_beta_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic w42 = reg_wr_in && reg_addr_in == 8'h42;
  wire logic w43 = reg_wr_in && reg_addr_in == 8'h43;
  wire logic w45 = reg_wr_in && reg_addr_in == 8'h45;
  wire logic w49 = reg_wr_in && reg_addr_in == 8'h49;
  a_rd_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read answer without a read");
  a_cap_select: assert property (w42 |-> ##2 cap_large_out == $past(reg_wdata_in[6], 2))
    else $error("capacitor select not from bit 6");
  a_div_decode: assert property (w42 |-> ##2
    charge_div_out == (5'h02 << $past(reg_wdata_in[5:4], 2)))
    else $error("charge divider decode wrong");
  a_bias_code: assert property (w42 |-> ##2 bias_sel_out == $past(reg_wdata_in[3:2], 2))
    else $error("bias code wrong");
  a_target_scale: assert property (w43 |-> ##2
    tune_target_out[0] == {$past(reg_wdata_in[5:0], 2), 5'h00})
    else $error("tuning target not times 32");
  a_acf_bypass: assert property (w45 |-> ##2 filter_bypass_out == $past(reg_wdata_in[4], 2))
    else $error("filter bypass not from bit 4");
  a_beta_offset: assert property (w45 |-> ##2
    lta_beta_out == 4'h7 + $past(reg_wdata_in[3:2], 2))
    else $error("average beta wrong");
  a_gain_place: assert property (w49 |-> ##2
    offset_out[1][9:8] == $past(reg_wdata_in[7:6], 2))
    else $error("channel 1 offset high bits wrong");
  a_mode_excl: assert property (mutual_ind_out[0] |-> !self_cap_out[0])
    else $error("both sensing modes active");
endmodule
bind scc_regs scc_regs_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in), .reg_rvalid_out(reg_rvalid_out), .self_cap_out(self_cap_out),
  .mutual_ind_out(mutual_ind_out), .tune_target_out(tune_target_out),
  .offset_out(offset_out), .cap_large_out(cap_large_out), .charge_div_out(charge_div_out),
  .bias_sel_out(bias_sel_out), .filter_bypass_out(filter_bypass_out),
  .lta_beta_out(lta_beta_out));

/* test/tb_top.sv */
// Self-checking bench for the sense channel register bank
`timescale 1ns/1ps
module tb_top;
  logic clk_in, rst_n_in, wr, rd, rvalid, load, cap_large, cs_div, two_sided, bypass;
  logic [7:0] addr, wdata, rdata;
  logic [5:0][15:0] raw;
  logic [1:0][15:0] filt, long_term_average;
  logic [1:0] self_cap, mut_ind, bias, prox, touch;
  logic [1:0][1:0] tx_en, rx_en, coarse;
  logic [1:0][7:0] base;
  logic [1:0][10:0] target;
  logic [1:0][9:0] offset;
  logic [1:0][3:0] fine;
  logic [4:0] div;
  logic [3:0] lbeta;
  logic [2:0] abeta;
  scc_pkg::scc_tune_e tmode;
  int n_errors, check_count;
  scc_host host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
    .rd_out(rd), .rdata_in(rdata), .rvalid_in(rvalid));
  scc_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .result_load_in(load), .raw_count_in(raw), .filt_count_in(filt), .lta_in(long_term_average),
    .self_cap_out(self_cap), .mutual_ind_out(mut_ind), .tx_en_out(tx_en), .rx_en_out(rx_en),
    .tune_base_out(base), .tune_target_out(target), .offset_out(offset),
    .coarse_out(coarse), .fine_out(fine), .cap_large_out(cap_large), .charge_div_out(div),
    .bias_sel_out(bias), .tune_mode_out(tmode), .cs_div_en_out(cs_div),
    .two_sided_out(two_sided), .filter_bypass_out(bypass), .lta_beta_out(lbeta),
    .acf_beta_out(abeta), .prox_out(prox), .touch_out(touch));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
  endtask
  task automatic pulse_load();
    @(negedge clk_in);
    load = 1'b1;
    @(negedge clk_in);
    load = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rchk(8'h40, 8'h00);
    rchk(8'h42, 8'h5b);
    rchk(8'h43, 8'h50);
    rchk(8'h45, 8'h00);
    chk("charge_div", 16'd4, 16'(div));
    chk("tune_target", 16'd512, 16'(target[0]));
  endtask
  task automatic t_front();
    for (int c = 0; c < 4; c++) begin
      host.wr_reg(8'h42, {1'b0, c[0], c[1:0], c[1:0], c[1:0]});
      chk("cap_large", 16'(c[0]), 16'(cap_large));
      chk("charge_div", 16'(2 << c), 16'(div));
      chk("bias_sel", 16'(c), 16'(bias));
      chk("tune_mode", 16'(c), 16'(tmode));
    end
  endtask
  task automatic t_method();
    for (int c = 0; c < 4; c++) begin
      host.wr_reg(8'h40, 8'(c));
      chk("rx_en", 16'(c), 16'(rx_en[0]));
      chk("tx_en", 16'h0, 16'(tx_en[0]));
      chk("self_cap", 16'h1, 16'(self_cap[0]));
    end
    host.wr_reg(8'h41, 8'h93);
    chk("mutual_ind", 16'h1, 16'(mut_ind[1]));
    rchk(8'h41, 8'h93);
  endtask
  task automatic t_tuning();
    int bases[4] = '{75, 100, 150, 200};
    for (int b = 0; b < 4; b++) begin
      host.wr_reg(8'h44, {b[1:0], 6'h3f});
      chk("tune_base", 16'(bases[b]), 16'(base[1]));
      chk("tune_target", 16'h3f * 16'd32, 16'(target[1]));
    end
    host.wr_reg(8'h43, 8'h01);
    chk("tune_target0", 16'd32, 16'(target[0]));
  endtask
  task automatic t_filter();
    host.wr_reg(8'h45, 8'h7f);
    chk("cs_div", 16'h1, 16'(cs_div));
    chk("two_sided", 16'h1, 16'(two_sided));
    chk("bypass", 16'h1, 16'(bypass));
    chk("lta_beta", 16'd10, 16'(lbeta));
    chk("acf_beta", 16'd4, 16'(abeta));
  endtask
  task automatic t_gain();
    host.wr_reg(8'h46, 8'ha5);
    host.wr_reg(8'h48, 8'h5e);
    host.wr_reg(8'h49, 8'hc7);
    host.wr_reg(8'h47, 8'h3c);
    chk("offset0", 16'h1a5, 16'(offset[0]));
    chk("offset1", 16'h33c, 16'(offset[1]));
    chk("coarse0", 16'h1, 16'(coarse[0]));
    chk("fine0", 16'he, 16'(fine[0]));
    chk("fine1", 16'h7, 16'(fine[1]));
  endtask
  task automatic t_results();
    host.wr_reg(8'h45, 8'h00);
    host.wr_reg(8'h50, 8'h10);
    host.wr_reg(8'h51, 8'h40);
    host.wr_reg(8'h20, 8'h55);
    pulse_load();
    chk("prox0", 16'h1, 16'(prox[0]));
    chk("touch0", 16'h0, 16'(touch[0]));
    rchk(8'h20, 8'he0);
    filt[0] = 16'hbeef;
    pulse_load();
    rchk(8'h21, 8'h00);
    rchk(8'h30, 8'h00);
    rchk(8'h31, 8'h01);
    host.wr_reg(8'h45, 8'h10);
    pulse_load();
    rchk(8'h20, 8'h34);
    chk("prox0", 16'h0, 16'(prox[0]));
    host.wr_reg(8'h45, 8'h30);
    chk("touch0", 16'h1, 16'(touch[0]));
    rchk(8'h24, 8'h78);
    rchk(8'h25, 8'h56);
    rchk(8'h60, 8'h00);
  endtask
  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end
  initial begin
    rst_n_in = 1'b0;
    load     = 1'b0;
    raw      = '0;
    raw[0]   = 16'h1234;
    raw[2]   = 16'h5678;
    filt     = '0;
    filt[0]  = 16'h00e0;
    long_term_average      = '0;
    long_term_average[0]   = 16'h0100;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_front();
    t_method();
    t_tuning();
    t_filter();
    t_gain();
    t_results();
    end_sim();
  end
endmodule
